/* logic/tcrf_pkg.sv */
package tcrf_pkg;
  localparam int DATA_W = 12;
  localparam int SUM_W = 14;
  localparam int N_SAMP = 7;
  localparam int N_DROP = 2;
  localparam int N_MID = 3;
  localparam logic [2:0] RANK_FIRST_MID = 3'(N_DROP);
  localparam logic [2:0] RANK_LAST_MID = 3'(N_DROP + N_MID - 1);
  localparam logic [2:0] LAST_FILT_IDX = 3'(N_SAMP - 1);
  localparam logic [SUM_W-1:0] MID_DIV = SUM_W'(N_MID);
  // Bus address of the device; the value is arbitrary.
  localparam logic [6:0] SLAVE_ADDR = 7'h4a;
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_FILT_BIT = 2;
  localparam logic [3:0] LSB_PAD = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

  typedef logic [DATA_W-1:0] tcrf_word_t;
  typedef enum logic [1:0] {COORD_X, COORD_Y, COORD_Z1, COORD_Z2} tcrf_coord_e;
  typedef enum logic [2:0] {B_IDLE, B_ADDR, B_AACK, B_CMD, B_CACK, B_TX, B_TACK} tcrf_bus_e;
  typedef enum logic [2:0] {C_OFF, C_SETTLE, C_SAMPLE, C_WAIT, C_DONE} tcrf_conv_e;

  typedef struct packed {
    logic power;
    logic x_drv;
    logic y_drv;
    logic z_drv;
  } tcrf_panel_s;

  typedef struct packed {
    tcrf_bus_e st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rd;
    logic ackd;
    logic byte2;
    logic oe_n;
  } tcrf_bus_s;

  localparam tcrf_panel_s PANEL_OFF = '{power: 1'h0, x_drv: 1'h0, y_drv: 1'h0, z_drv: 1'h0};
  localparam tcrf_bus_s BUS_RST = '{st: B_IDLE, sh: 8'h00, cnt: 4'h0, rd: 1'h0, ackd: 1'h0,
                                    byte2: 1'h0, oe_n: 1'h1};
endpackage

/* logic/tcrf_median_avg.sv */
module tcrf_median_avg (
  // Samples
  input wire logic [tcrf_pkg::N_SAMP-1:0][tcrf_pkg::DATA_W-1:0] samples_in,
  // Result
  output logic [tcrf_pkg::DATA_W-1:0] avg_out
);
  import tcrf_pkg::*;

  logic [N_SAMP-1:0][SUM_W-1:0] part;
  logic [SUM_W-1:0] sum;

  // Equal samples are ranked by index so that exactly three land in the middle.
  for (genvar i = 0; i < N_SAMP; i++) begin : g_rank
    logic [2:0] rank;
    always_comb begin
      rank = 3'h0;
      for (int j = 0; j < N_SAMP; j++) begin
        if ((samples_in[j] < samples_in[i]) || ((samples_in[j] == samples_in[i]) && (j < i))) begin
          rank = rank + 3'h1;
        end
      end
    end
    assign part[i] = ((rank >= RANK_FIRST_MID) && (rank <= RANK_LAST_MID)) ?
                     {2'h0, samples_in[i]} : '0;
  end

  always_comb begin
    sum = '0;
    for (int i = 0; i < N_SAMP; i++) begin
      sum = sum + part[i];
    end
  end

  // Integer division drops the fraction, which keeps the result in twelve bits.
  assign avg_out = DATA_W'(sum / MID_DIV);
endmodule

/* logic/tcrf_top.sv */
module tcrf_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Two-wire serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Panel side
  input wire logic pen_detect_in,
  output logic pen_touch_interrupt_n_out,
  output tcrf_pkg::tcrf_panel_s panel_out,
  // Converter
  output logic adc_start_out,
  output tcrf_pkg::tcrf_coord_e adc_sel_out,
  input wire logic adc_done_in,
  input wire logic [tcrf_pkg::DATA_W-1:0] adc_data_in,
  // Status
  output logic busy_out
);
  import tcrf_pkg::*;

  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic pen_s1_ff, pen_s2_ff;
  logic scl_rise, scl_fall, start_cond, stop_cond, awake, cmd_go;
  tcrf_bus_s bus_ff, nxt_bus;
  tcrf_conv_e conv_ff, nxt_conv;
  tcrf_coord_e sel_ff, nxt_sel;
  logic filt_ff, nxt_filt;
  logic [7:0] wait_ff, nxt_wait;
  logic [2:0] scnt_ff, nxt_scnt;
  logic [N_SAMP-1:0][DATA_W-1:0] samp_ff, nxt_samp;
  tcrf_word_t res_ff, nxt_res, filt_avg;
  tcrf_panel_s panel_ff, nxt_panel;
  logic start_ff, nxt_start;
  logic irq_n_ff, nxt_irq_n, busy_ff;

  // Pins are outside the clock domain; edges are found on the second and third stages.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      scl_s1_ff <= 1'h1;
      scl_s2_ff <= 1'h1;
      scl_s3_ff <= 1'h1;
      sda_s1_ff <= 1'h1;
      sda_s2_ff <= 1'h1;
      sda_s3_ff <= 1'h1;
      pen_s1_ff <= 1'h0;
      pen_s2_ff <= 1'h0;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
      pen_s1_ff <= pen_detect_in;
      pen_s2_ff <= pen_s1_ff;
    end
  end

  assign scl_rise = scl_s2_ff && !scl_s3_ff;
  assign scl_fall = !scl_s2_ff && scl_s3_ff;
  assign start_cond = scl_s2_ff && scl_s3_ff && !sda_s2_ff && sda_s3_ff;
  assign stop_cond = scl_s2_ff && scl_s3_ff && sda_s2_ff && !sda_s3_ff;
  // With no touch and nothing pending the device does not answer its address.
  assign awake = pen_s2_ff || (conv_ff != C_OFF);

  always_comb begin
    nxt_bus = bus_ff;
    cmd_go = 1'h0;
    if (start_cond) begin
      nxt_bus = BUS_RST;
      nxt_bus.st = B_ADDR;
    end else if (stop_cond) begin
      nxt_bus = BUS_RST;
    end else begin
      case (bus_ff.st)
        B_ADDR, B_CMD: begin
          if (scl_rise) begin
            nxt_bus.sh = {bus_ff.sh[6:0], sda_s2_ff};
            nxt_bus.cnt = bus_ff.cnt + 4'h1;
            if (bus_ff.cnt == BITS_PER_BYTE - 4'h1) begin
              nxt_bus.st = (bus_ff.st == B_ADDR) ? B_AACK : B_CACK;
              nxt_bus.ackd = 1'h0;
            end
          end
        end
        B_AACK: begin
          if (scl_fall) begin
            if (!bus_ff.ackd) begin
              if ((bus_ff.sh[7:1] == SLAVE_ADDR) && awake) begin
                nxt_bus.oe_n = 1'h0;
                nxt_bus.ackd = 1'h1;
                nxt_bus.rd = bus_ff.sh[0];
              end else begin
                nxt_bus.st = B_IDLE;
              end
            end else if (bus_ff.rd) begin
              // First data bit goes out on the same falling edge that ends the acknowledge.
              nxt_bus.st = B_TX;
              nxt_bus.oe_n = res_ff[DATA_W-1];
              nxt_bus.sh = {res_ff[DATA_W-2:4], 1'h0};
              nxt_bus.cnt = 4'h1;
              nxt_bus.byte2 = 1'h0;
            end else begin
              nxt_bus.oe_n = 1'h1;
              nxt_bus.st = B_CMD;
              nxt_bus.cnt = 4'h0;
            end
          end
        end
        B_CACK: begin
          if (scl_fall) begin
            if (!bus_ff.ackd) begin
              nxt_bus.oe_n = 1'h0;
              nxt_bus.ackd = 1'h1;
              cmd_go = 1'h1;
            end else begin
              nxt_bus.oe_n = 1'h1;
              nxt_bus.st = B_IDLE;
            end
          end
        end
        B_TX: begin
          if (scl_fall) begin
            if (bus_ff.cnt == BITS_PER_BYTE) begin
              nxt_bus.oe_n = 1'h1;
              nxt_bus.st = B_TACK;
            end else begin
              nxt_bus.oe_n = bus_ff.sh[7];
              nxt_bus.sh = {bus_ff.sh[6:0], 1'h0};
              nxt_bus.cnt = bus_ff.cnt + 4'h1;
            end
          end
        end
        B_TACK: begin
          if (scl_rise) begin
            // Twelve bits leave as a high byte then a low nibble padded with zeros.
            if (!sda_s2_ff && !bus_ff.byte2) begin
              nxt_bus.st = B_TX;
              nxt_bus.sh = {res_ff[3:0], LSB_PAD};
              nxt_bus.cnt = 4'h0;
              nxt_bus.byte2 = 1'h1;
            end else begin
              nxt_bus.st = B_IDLE;
            end
          end
        end
        default: begin
          nxt_bus.st = bus_ff.st;
        end
      endcase
    end
  end

  always_comb begin
    nxt_conv = conv_ff;
    nxt_sel = sel_ff;
    nxt_filt = filt_ff;
    nxt_wait = wait_ff;
    nxt_scnt = scnt_ff;
    nxt_samp = samp_ff;
    nxt_res = res_ff;
    nxt_panel = panel_ff;
    nxt_start = 1'h0;
    // Driving the panel disturbs pen sensing, so the interrupt only shows while idle.
    nxt_irq_n = !(pen_s2_ff && (conv_ff == C_OFF));
    case (conv_ff)
      C_OFF: begin
        // Commands arriving while a conversion runs are ignored.
        if (cmd_go) begin
          nxt_sel = tcrf_coord_e'(bus_ff.sh[CMD_SEL_LSB +: 2]);
          nxt_filt = bus_ff.sh[CMD_FILT_BIT];
          nxt_panel.power = 1'h1;
          nxt_panel.x_drv = (bus_ff.sh[CMD_SEL_LSB +: 2] == COORD_X);
          nxt_panel.y_drv = (bus_ff.sh[CMD_SEL_LSB +: 2] == COORD_Y);
          nxt_panel.z_drv = bus_ff.sh[CMD_SEL_LSB + 1];
          nxt_wait = 8'h00;
          nxt_conv = C_SETTLE;
        end
      end
      C_SETTLE: begin
        nxt_wait = wait_ff + 8'h01;
        if (wait_ff == SETTLE_LAST) begin
          nxt_scnt = 3'h0;
          nxt_conv = C_SAMPLE;
        end
      end
      C_SAMPLE: begin
        nxt_start = 1'h1;
        nxt_conv = C_WAIT;
      end
      C_WAIT: begin
        if (adc_done_in) begin
          nxt_samp[scnt_ff] = adc_data_in;
          nxt_scnt = scnt_ff + 3'h1;
          // Driver stays on between samples; it is switched only once per request.
          if (scnt_ff == (filt_ff ? LAST_FILT_IDX : 3'h0)) begin
            nxt_conv = C_DONE;
          end else begin
            nxt_conv = C_SAMPLE;
          end
        end
      end
      C_DONE: begin
        nxt_res = filt_ff ? filt_avg : samp_ff[0];
        nxt_panel = PANEL_OFF;
        nxt_conv = C_OFF;
      end
      default: begin
        nxt_conv = C_OFF;
      end
    endcase
  end

  tcrf_median_avg u_filter (
    .samples_in(samp_ff),
    .avg_out(filt_avg)
  );

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      bus_ff <= BUS_RST;
      conv_ff <= C_OFF;
      sel_ff <= COORD_X;
      filt_ff <= 1'h0;
      wait_ff <= 8'h00;
      scnt_ff <= 3'h0;
      samp_ff <= '0;
      res_ff <= '0;
      panel_ff <= PANEL_OFF;
      start_ff <= 1'h0;
      irq_n_ff <= 1'h1;
      busy_ff <= 1'h0;
      sda_out <= 1'h0;
    end else begin
      bus_ff <= nxt_bus;
      conv_ff <= nxt_conv;
      sel_ff <= nxt_sel;
      filt_ff <= nxt_filt;
      wait_ff <= nxt_wait;
      scnt_ff <= nxt_scnt;
      samp_ff <= nxt_samp;
      res_ff <= nxt_res;
      panel_ff <= nxt_panel;
      start_ff <= nxt_start;
      irq_n_ff <= nxt_irq_n;
      busy_ff <= (nxt_conv != C_OFF);
      sda_out <= 1'h0;
    end
  end

  assign sda_oe_n_out = bus_ff.oe_n;
  assign panel_out = panel_ff;
  assign adc_start_out = start_ff;
  assign adc_sel_out = sel_ff;
  assign pen_touch_interrupt_n_out = irq_n_ff;
  assign busy_out = busy_ff;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_idle_quiet: assert property ((conv_ff == C_OFF) |-> (panel_out == PANEL_OFF) && !adc_start_out)
    else $error("panel or converter active while idle");
  a_irq_on_pen: assert property (pen_s2_ff && (conv_ff == C_OFF) |=> !pen_touch_interrupt_n_out)
    else $error("pen interrupt not asserted on touch");
  a_x_driver_on: assert property (cmd_go && (conv_ff == C_OFF) && (bus_ff.sh[1:0] == COORD_X)
    |=> panel_out.x_drv && panel_out.power && !adc_start_out)
    else $error("x driver not on after x command");
  a_seven_samples: assert property ((conv_ff == C_DONE) && filt_ff |-> (scnt_ff == 3'h7))
    else $error("filtered result without seven samples");
  a_result_filtered: assert property ((conv_ff == C_DONE) && filt_ff |=> (res_ff == $past(filt_avg)))
    else $error("result not taken from filter");
  a_driver_once: assert property ((conv_ff != C_OFF) && $past(conv_ff != C_OFF) && (conv_ff != C_SETTLE)
    |-> $stable(panel_out) || (conv_ff == C_OFF))
    else $error("panel driver toggled during sampling");
  a_tx_bits: assert property ((bus_ff.st == B_TX) && scl_fall && !start_cond && !stop_cond
    && (bus_ff.cnt < BITS_PER_BYTE) |=> (sda_oe_n_out == $past(bus_ff.sh[7])))
    else $error("serial bit does not match result");
  a_second_byte: assert property ((bus_ff.st == B_TACK) && scl_rise && !sda_s2_ff && !bus_ff.byte2
    && !start_cond && !stop_cond |=> (bus_ff.sh == {res_ff[3:0], LSB_PAD}) && (bus_ff.st == B_TX))
    else $error("low nibble not loaded after master acknowledge");
  a_power_down: assert property ((conv_ff == C_DONE) |=> (panel_out == PANEL_OFF) ##1 !panel_out.power)
    else $error("panel not powered down after conversion");
endmodule

/* test/tcrf_host_model.sv */
module tcrf_host_model (
  // Bus pins
  output logic scl_out,
  output logic sda_pull_n_out,
  input wire logic sda_in,
  // Device status
  input wire logic busy_in,
  input wire logic irq_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcrf_pkg::*;
  logic masked = 1'b0;
  logic [3:0] pad_seen = 4'hf;
  initial begin
    scl_out = 1'b1;
    sda_pull_n_out = 1'b1;
  end
  task automatic start_cond();
    sda_pull_n_out = 1'b1;
    #31.25 scl_out = 1'b1;
    #31.25 sda_pull_n_out = 1'b0;
    #31.25 scl_out = 1'b0;
  endtask
  task automatic stop_cond();
    #31.25 sda_pull_n_out = 1'b0;
    #31.25 scl_out = 1'b1;
    #31.25 sda_pull_n_out = 1'b1;
    #31.25;
  endtask
  // A 1 in tx releases the line, so the same task writes bytes and reads them.
  task automatic bits9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #31.25 sda_pull_n_out = tx[i];
      #31.25 scl_out = 1'b1;
      #31.25 rx[i] = sda_in;
      #31.25 scl_out = 1'b0;
    end
  endtask
  task automatic measure(input logic [7:0] cmd, output logic [DATA_W-1:0] res, output logic acked);
    logic [8:0] rx;
    logic [8:0] rx2;
    res = '0;
    pad_seen = 4'hf;
    start_cond();
    bits9({SLAVE_ADDR, 1'b0, 1'b1}, rx);
    acked = ~rx[0];
    if (acked) begin
      bits9({cmd, 1'b1}, rx);
      #100;
      // There is no clock stretching, so the host waits for busy to drop itself.
      for (int i = 0; i < 400 && busy_in !== 1'b0; i++) #8;
      start_cond();
      bits9({SLAVE_ADDR, 1'b1, 1'b1}, rx);
      bits9({8'hff, 1'b0}, rx);
      bits9({8'hff, 1'b1}, rx2);
      res = {rx[8:1], rx2[8:5]};
      pad_seen = rx2[4:1];
    end
    stop_cond();
  endtask
  task automatic take_irq(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 100 && !seen; i++) #8 seen = (irq_n_in === 1'b0);
    masked = seen;
  endtask
  task automatic unmask();
    masked = 1'b0;
  endtask
endmodule

/* test/test_touch_command_readout_filter.sv */
module test_touch_command_readout_filter;
  timeunit 1ns;
  timeprecision 1ps;
  import tcrf_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic [N_SAMP-1:0][DATA_W-1:0] samp;
    tcrf_word_t exp;
  } tcrf_row_s;
  tcrf_row_s rows [5] = '{
    '{8'h04, {12'h100, 12'h900, 12'h300, 12'h200, 12'h800, 12'h400, 12'h500}, 12'h400},
    '{8'h05, {12'hfff, 12'h000, 12'hfff, 12'h000, 12'h7ff, 12'h800, 12'h801}, 12'h800},
    '{8'h06, {12'h010, 12'h011, 12'h010, 12'h012, 12'h010, 12'h011, 12'h013}, 12'h010},
    '{8'h07, {7{12'hfff}}, 12'hfff},
    '{8'h03, {12'h123, 12'h456, 12'h789, 12'h0ab, 12'hcde, 12'hf01, 12'habc}, 12'habc}};
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pen_detect_in = 1'b0;
  logic adc_done_in = 1'b0;
  logic [DATA_W-1:0] adc_data_in = '0;
  logic scl_w, host_sda_n, sda_out, sda_oe_n_out, irq_n, adc_start_out, busy_out, prev_pwr;
  tcrf_panel_s panel_out;
  tcrf_panel_s drv_seen;
  tcrf_coord_e adc_sel_out;
  tcrf_coord_e sel_seen;
  tcrf_row_s cur;
  int err_total = 0;
  int n_compared = 0;
  int k = 0;
  int pwr_ons = 0;
  wire logic sda_w = host_sda_n & (sda_oe_n_out ? 1'b1 : sda_out);
  always #4 mclk_in = ~mclk_in;
  tcrf_top dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .pen_detect_in(pen_detect_in),
    .pen_touch_interrupt_n_out(irq_n), .panel_out(panel_out), .adc_start_out(adc_start_out),
    .adc_sel_out(adc_sel_out), .adc_done_in(adc_done_in), .adc_data_in(adc_data_in), .busy_out(busy_out));
  tcrf_host_model u_host (.scl_out(scl_w), .sda_pull_n_out(host_sda_n), .sda_in(sda_w),
    .busy_in(busy_out), .irq_n_in(irq_n));
  always @(negedge mclk_in) begin
    adc_done_in <= (adc_start_out === 1'b1);
    if (adc_start_out === 1'b1) begin
      adc_data_in <= cur.samp[k];
      k <= k + 1;
      drv_seen <= panel_out;
      sel_seen <= adc_sel_out;
    end
  end
  always @(posedge mclk_in) begin
    prev_pwr <= panel_out.power;
    if (panel_out.power === 1'b1 && prev_pwr === 1'b0) pwr_ons <= pwr_ons + 1;
  end
  task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_quiet(input string what);
    logic bad;
    bad = 1'b0;
    repeat (50) begin
      @(negedge mclk_in);
      if (panel_out !== PANEL_OFF || sda_oe_n_out !== 1'b1 || irq_n !== 1'b1 || adc_start_out !== 1'b0) bad = 1'b1;
    end
    chk_bit(what, 1'b0, bad);
  endtask
  task automatic wrap_up();
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #300us;
    err_total++;
    $display("Error watchdog expected finish seen hang");
    wrap_up();
  end
  initial begin
    logic [DATA_W-1:0] res;
    logic ok;
    logic seen;
    cur = rows[0];
    repeat (12) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    chk_quiet("idle quiet");
    u_host.measure(8'h04, res, ok);
    chk_bit("ack while untouched", 1'b0, ok);
    $display("idle test done");
    @(negedge mclk_in);
    pen_detect_in = 1'b1;
    foreach (rows[r]) begin
      cur = rows[r];
      k = 0;
      pwr_ons = 0;
      u_host.take_irq(seen);
      chk_bit("pen irq", 1'b1, seen);
      u_host.measure(cur.cmd, res, ok);
      chk_word("result", cur.exp, res);
      chk_word("low nibble pad", 12'(LSB_PAD), 12'(u_host.pad_seen));
      chk_word("conversions", cur.cmd[CMD_FILT_BIT] ? 12'h7 : 12'h1, 12'(k));
      chk_word("power-ups", 12'h1, 12'(pwr_ons));
      chk_word("coordinate", 12'(cur.cmd[1:0]), 12'(sel_seen));
      chk_word("drivers", 12'({1'b1, cur.cmd[1:0] == 2'h0, cur.cmd[1:0] == 2'h1, cur.cmd[1]}), 12'(drv_seen));
      $display("row %0d done", r);
    end
    u_host.unmask();
    u_host.take_irq(seen);
    chk_bit("touch persists", 1'b1, seen);
    // A reset in mid-conversion must drop the panel drive at once.
    fork
      u_host.measure(8'h04, res, ok);
      begin
        for (int i = 0; i < 3000 && busy_out !== 1'b1; i++) @(negedge mclk_in);
        sys_rst_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        @(negedge mclk_in);
        chk_word("panel after reset", 12'(PANEL_OFF), 12'(panel_out));
        chk_bit("busy after reset", 1'b0, busy_out);
      end
    join
    $display("reset test done");
    @(negedge mclk_in);
    pen_detect_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    chk_quiet("quiet after release");
    u_host.measure(8'h05, res, ok);
    chk_bit("ack after release", 1'b0, ok);
    $display("release test done");
    wrap_up();
  end
endmodule
